/* File: dv/pin_model.sv */
// far-side model driving the count pin, external interrupt pin and port inputs
`timescale 1ns/1ns
`default_nettype none
module pin_model (
    input wire logic mclk,
    output logic count_pin,
    output logic ext_irq_pin,
    output logic [7:0] port_in
);
    // idle levels: count low, interrupt pin high as if pulled up, port quiet
    initial begin
        count_pin = 1'b0;
        ext_irq_pin = 1'b1;
        port_in = 8'h00;
    end
    // every level stands three edges so the one-cycle edge history never misses one
    task automatic hold();
        repeat (3) @(posedge mclk);
    endtask : hold
    task automatic set_count(input logic v);
        count_pin <= v;
        hold();
    endtask : set_count
    task automatic count_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            set_count(1'b1);
            set_count(1'b0);
        end
    endtask : count_pulses
    task automatic ext_fall();
        ext_irq_pin <= 1'b0;
        hold();
        ext_irq_pin <= 1'b1;
        hold();
    endtask : ext_fall
    task automatic port_set(input logic [7:0] v);
        port_in <= v;
        hold();
    endtask : port_set
endmodule : pin_model
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench: registers over avalon, pins through the far-side model
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import tmr_pkg::*;
    // short watchdog step keeps a full timeout near a thousand cycles
    localparam int WDT_TICK = 4;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest, count_pin, ext_irq_pin, watchdog_reset, irq_request, sleeping, count_pin_timer, ext_pin_irq;
    logic [7:0] port_in;
    logic [7:0] rdv;
    int mismatches = 0;
    int check_count = 0;
    int n;

    // free-running clock
    always #2 mclk = ~mclk;

    pin_model pins (.mclk(mclk), .count_pin(count_pin), .ext_irq_pin(ext_irq_pin), .port_in(port_in));

    timer_watchdog_irq_flags #(.WDT_TICK(WDT_TICK)) dut (.mclk(mclk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .count_pin(count_pin), .ext_irq_pin(ext_irq_pin), .port_in(port_in),
        .watchdog_reset(watchdog_reset), .irq_request(irq_request), .sleeping(sleeping),
        .count_pin_timer(count_pin_timer), .ext_pin_irq(ext_pin_irq));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h0, exp}, {7'h0, got});
    endtask : chk1

    // counts that depend on clock phase are allowed a small window
    task automatic chk_near(input string what, input int exp, input logic [15:0] got, input int tol);
        check_count++;
        if ((got >= exp - tol && got <= exp + tol) !== 1'b1) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_near

    // one avalon access: hold everything until waitrequest is sampled low
    task automatic bus(input logic rnw, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        int k;
        k = 0;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        read <= rnw;
        write <= ~rnw;
        do begin
            @(posedge mclk);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        rdv = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
        if (k >= 20) begin
            chk1("waitrequest", 1'b0, waitrequest);
        end
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 4'h1);
    endtask : wr

    task automatic rdchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] exp, input string what);
        bus(1'b1, a, 8'h00, 4'h1);
        chk8(what, exp, rdv & m);
    endtask : rdchk

    task automatic wdt_wait();
        n = 0;
        while (watchdog_reset !== 1'b1 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
    endtask : wdt_wait

    task automatic t_reset();
        rdchk(ADDR_STATUS, 8'hff, 8'h18, "status");
        rdchk(ADDR_TCTRL, 8'hff, 8'h3f, "timer_control");
        rdchk(ADDR_WCTRL, 8'hff, 8'h80, "watchdog_control");
        rdchk(ADDR_IFLAG, 8'hff, 8'h00, "interrupt_flags");
        chk1("count_pin_timer", 1'b1, count_pin_timer);
        chk1("ext_pin_irq", 1'b0, ext_pin_irq);
        bus(1'b0, ADDR_IMASK, 8'h07, 4'he);
        rdchk(ADDR_IMASK, 8'hff, 8'h00, "lane-off write");
        wr(ADDR_WCTRL, 8'h00);
    endtask : t_reset

    task automatic t_internal();
        for (int opt = 0; opt < 2; opt++) begin
            wr(ADDR_TCTRL, 8'h08);
            wr(ADDR_CFG, 8'(opt));
            chk1("count_pin_timer", 1'b0, count_pin_timer);
            wr(ADDR_TICK, 8'h00);
            repeat (80) @(posedge mclk);
            bus(1'b1, ADDR_TICK, 8'h00, 4'h1);
            chk_near("tick rate", 82 >> (opt + 1), {8'h00, rdv}, 2);
        end
    endtask : t_internal

    task automatic t_overflow();
        wr(ADDR_TCTRL, 8'h28);
        wr(ADDR_IMASK, 8'h01);
        wr(ADDR_TICK, 8'hfe);
        pins.count_pulses(2);
        rdchk(ADDR_TICK, 8'hff, 8'h00, "tick wrap");
        rdchk(ADDR_IFLAG, 8'hff, 8'h01, "overflow flag");
        wr(ADDR_IMASK, 8'h00);
        rdchk(ADDR_IFLAG, 8'hff, 8'h00, "masked flags");
        wr(ADDR_IMASK, 8'h07);
        wr(ADDR_IFLAG, 8'hff);
        rdchk(ADDR_IFLAG, 8'hff, 8'h01, "flag kept");
        wr(ADDR_IFLAG, 8'h00);
        wr(ADDR_IFLAG, 8'hff);
        rdchk(ADDR_IFLAG, 8'hff, 8'h00, "flag written");
    endtask : t_overflow

    // ends on a rising edge so the two edge selections give different counts
    task automatic t_edge();
        for (int e = 0; e < 2; e++) begin
            wr(ADDR_TCTRL, 8'h28 | 8'(e << 4));
            wr(ADDR_TICK, 8'h00);
            pins.count_pulses(3);
            pins.set_count(1'b1);
            rdchk(ADDR_TICK, 8'hff, 8'(4 - e), "edge count");
            pins.set_count(1'b0);
        end
    endtask : t_edge

    task automatic t_prescale();
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_TCTRL, 8'h20 | 8'(k));
            wr(ADDR_TICK, 8'h00);
            pins.count_pulses(3 << (k + 1));
            rdchk(ADDR_TICK, 8'hff, 8'h03, "prescaled count");
        end
        wr(ADDR_TICK, 8'h00);
        pins.count_pulses(5);
        wr(ADDR_TCTRL, 8'h2a);
        wr(ADDR_TCTRL, 8'h22);
        pins.count_pulses(3);
        rdchk(ADDR_TICK, 8'hff, 8'h00, "swap clears prescaler");
    endtask : t_prescale

    task automatic t_ext();
        wr(ADDR_IMASK, 8'h04);
        pins.ext_fall();
        rdchk(ADDR_IFLAG, 8'hff, 8'h00, "ext blocked");
        wr(ADDR_WCTRL, 8'h40);
        chk1("ext_pin_irq", 1'b1, ext_pin_irq);
        pins.ext_fall();
        rdchk(ADDR_IFLAG, 8'hff, 8'h04, "ext flag");
        // commands in turn: on, off, return, taken
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CMD, 8'h04 << i);
            repeat (2) @(posedge mclk);
            chk1("irq_request", ~i[0], irq_request);
            rdchk(ADDR_TCTRL, 8'h40, {1'b0, ~i[0], 6'h0}, "global enable");
        end
        wr(ADDR_CMD, 8'h04);
        wr(ADDR_IMASK, 8'h00);
        repeat (2) @(posedge mclk);
        chk1("irq_request masked", 1'b0, irq_request);
        wr(ADDR_CMD, 8'h08);
        wr(ADDR_IFLAG, 8'h00);
    endtask : t_ext

    task automatic t_sleep();
        wr(ADDR_IMASK, 8'h02);
        wr(ADDR_CMD, 8'h02);
        repeat (2) @(posedge mclk);
        chk1("sleeping", 1'b1, sleeping);
        rdchk(ADDR_STATUS, 8'h98, 8'h10, "status in sleep");
        pins.port_set(8'h5a);
        repeat (2) @(posedge mclk);
        chk1("woken", 1'b0, sleeping);
        rdchk(ADDR_STATUS, 8'h80, 8'h80, "wake cause");
        rdchk(ADDR_IFLAG, 8'hff, 8'h02, "pin change flag");
        wr(ADDR_CMD, 8'h01);
        rdchk(ADDR_STATUS, 8'h18, 8'h18, "clear status");
        wr(ADDR_IFLAG, 8'h00);
    endtask : t_sleep

    task automatic t_watchdog();
        wr(ADDR_TCTRL, 8'h20);
        wr(ADDR_WCTRL, 8'h80);
        wr(ADDR_CMD, 8'h01);
        wdt_wait();
        chk_near("watchdog period", 256 * WDT_TICK, n[15:0], 8);
        rdchk(ADDR_STATUS, 8'h98, 8'h08, "timeout status");
        wr(ADDR_TCTRL, 8'h29);
        wr(ADDR_CMD, 8'h01);
        wdt_wait();
        chk_near("watchdog prescaled", 512 * WDT_TICK, n[15:0], 12);
        wr(ADDR_WCTRL, 8'h00);
        wdt_wait();
        chk1("watchdog off", 1'b0, watchdog_reset);
    endtask : t_watchdog

    // main sequence
    initial begin
        address <= 5'h00;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= 32'h0000_0000;
        byteenable <= 4'h0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_internal();
        t_overflow();
        t_edge();
        t_prescale();
        t_ext();
        t_sleep();
        t_watchdog();
        report_and_stop();
    end

    // hang guard, well beyond the roughly eight thousand cycles the run needs
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        $display("mismatch run time expected end seen hang");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire

/* File: src/presc_div.sv */
// shared 8-bit prescaler with selectable power-of-two carry
`timescale 1ns/1ns
`default_nettype none
module presc_div (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic step,
    input wire logic [3:0] shift,
    output logic fire
);
    import tmr_pkg::*;

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [8:0] mask_w;

    // fire on the step that completes 2^shift steps; shift 0 passes every step
    assign mask_w = (9'h001 << shift) - 9'h001;
    assign fire = step & (&(cnt_q | ~mask_w[7:0]));
    assign cnt_d = clear ? 8'h00 : (step ? cnt_q + 8'h01 : cnt_q);

    // counter; clear beats step so a cleared prescaler starts from zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    property p_clear_zero;
        @(posedge mclk) disable iff (sys_rst) clear |=> cnt_q == 8'h00;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("prescaler not cleared");
endmodule : presc_div
`default_nettype wire

/* File: src/timer_watchdog_irq_flags.sv */
// tick counter, watchdog, shared prescaler, reset-cause and interrupt flags
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module timer_watchdog_irq_flags #(
    parameter int WDT_TICK = tmr_pkg::WDT_TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic count_pin,
    input wire logic ext_irq_pin,
    input wire logic [7:0] port_in,
    output logic watchdog_reset,
    output logic irq_request,
    output logic sleeping,
    output logic count_pin_timer,
    output logic ext_pin_irq
);
    import tmr_pkg::*;

    logic wait_q;
    logic [31:0] readdata_q;
    logic [7:0] tick_q;
    logic [6:0] tctrl_q;
    logic [1:0] wctrl_q;
    logic [2:0] flags_q;
    logic [2:0] imask_q;
    logic clk_opt_q;
    logic pd_q;
    logic to_q;
    logic rst_type_q;
    logic [1:0] spare_q;
    pwr_state_e state_q;
    logic [1:0] cyc_q;
    logic [OSC_W-1:0] osc_q;
    logic [7:0] wdt_q;
    logic wdt_rst_q;
    logic irq_q;
    logic cnt_prev_q;
    logic ext_prev_q;
    logic [7:0] port_prev_q;

    // bus decode; an access completes on the edge where waitrequest is low
    logic acc;
    logic wr_en;
    logic wr_tick;
    logic wr_status;
    logic wr_iflag;
    logic wr_tctrl;
    logic wr_wctrl;
    logic wr_imask;
    logic wr_cmd;
    logic wr_cfg;
    assign acc = (read | write) & ~wait_q;
    assign wr_en = acc & write & byteenable[0];
    assign wr_tick = wr_en & (address == ADDR_TICK);
    assign wr_status = wr_en & (address == ADDR_STATUS);
    assign wr_iflag = wr_en & (address == ADDR_IFLAG);
    assign wr_tctrl = wr_en & (address == ADDR_TCTRL);
    assign wr_wctrl = wr_en & (address == ADDR_WCTRL);
    assign wr_imask = wr_en & (address == ADDR_IMASK);
    assign wr_cmd = wr_en & (address == ADDR_CMD);
    assign wr_cfg = wr_en & (address == ADDR_CFG);

    // one-shot instruction strobes
    logic do_kick;
    logic do_sleep;
    logic do_gie_set;
    logic do_gie_clr;
    assign do_kick = wr_cmd & writedata[CMD_WDT_CLR];
    assign do_sleep = wr_cmd & writedata[CMD_SLEEP];
    assign do_gie_set = wr_cmd & (writedata[CMD_IRQ_ON] | writedata[CMD_IRQ_RET]);
    assign do_gie_clr = wr_cmd & (writedata[CMD_IRQ_OFF] | writedata[CMD_IRQ_TAKEN]);

    // control fields
    logic assign_wdt;
    logic [2:0] ratio;
    logic wdt_on;
    logic ext_sel;
    assign assign_wdt = tctrl_q[TC_ASSIGN];
    assign ratio = tctrl_q[2:0];
    assign wdt_on = wctrl_q[1];
    assign ext_sel = wctrl_q[0];

    // instruction cycle from the clock option; it stops while asleep
    logic instr_tick;
    assign instr_tick = (state_q == ST_RUN) & (clk_opt_q ? (cyc_q == 2'd3) : cyc_q[0]);

    // pin events; inputs arrive synchronous so one stage of history suffices
    logic cnt_rise;
    logic cnt_fall;
    logic ext_fall;
    logic port_chg;
    assign cnt_rise = count_pin & ~cnt_prev_q;
    assign cnt_fall = ~count_pin & cnt_prev_q;
    assign ext_fall = ext_sel & ~ext_irq_pin & ext_prev_q;
    assign port_chg = port_in != port_prev_q;

    // tick source: count pin edge or instruction cycle
    logic tick_src;
    assign tick_src = tctrl_q[TC_SRC] ? (tctrl_q[TC_EDGE] ? cnt_fall : cnt_rise) : instr_tick;

    // watchdog oscillator stand-in, free running even in sleep
    logic osc_tick;
    assign osc_tick = osc_q == OSC_W'(WDT_TICK - 1);

    // prescaler hookup: tick gets 2^(n+1), watchdog 2^n
    logic pre_clr;
    logic pre_step;
    logic [3:0] pre_shift;
    logic pre_fire;
    assign pre_step = assign_wdt ? osc_tick : tick_src;
    assign pre_shift = assign_wdt ? {1'b0, ratio} : {1'b0, ratio} + 4'd1;
    assign pre_clr = (wr_tick & ~assign_wdt)
        | ((do_kick | do_sleep) & assign_wdt)
        | (wr_tctrl & (writedata[TC_ASSIGN] != assign_wdt));

    presc_div u_presc (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clear(pre_clr),
        .step(pre_step),
        .shift(pre_shift),
        .fire(pre_fire)
    );

    // counter steps after routing through or around the prescaler
    logic tick_inc;
    logic tick_wrap;
    logic wdt_inc;
    logic wdt_clr;
    logic wdt_to;
    assign tick_inc = assign_wdt ? tick_src : pre_fire;
    assign tick_wrap = tick_inc & ~wr_tick & (tick_q == 8'hff);
    assign wdt_inc = wdt_on & (assign_wdt ? pre_fire : osc_tick);
    assign wdt_clr = do_kick | do_sleep;
    // a clear in the same cycle wins so software never races its own kick
    assign wdt_to = wdt_inc & ~wdt_clr & (wdt_q == 8'hff);

    // pin-change wake from sleep, only when that source is enabled
    logic wake;
    assign wake = (state_q == ST_SLEEP) & port_chg & imask_q[IRQ_PIN];

    // read mux; unmapped addresses read zero
    logic [7:0] status_rd;
    logic [7:0] rd_mux;
    assign status_rd = {rst_type_q, spare_q[1], spare_q[0], to_q, pd_q, 3'h0};
    assign rd_mux = (address == ADDR_TICK) ? tick_q
        : (address == ADDR_STATUS) ? status_rd
        : (address == ADDR_IFLAG) ? {5'h00, flags_q & imask_q}
        : (address == ADDR_TCTRL) ? {1'b0, tctrl_q}
        : (address == ADDR_WCTRL) ? {wctrl_q, 6'h00}
        : (address == ADDR_IMASK) ? {5'h00, imask_q}
        : (address == ADDR_CFG) ? {7'h00, clk_opt_q}
        : 8'h00;

    // flag events and clears; an event in the clearing cycle survives
    logic [2:0] evt;
    logic [2:0] keep;
    logic [2:0] flags_d;
    assign evt = {ext_fall, port_chg, tick_wrap};
    assign keep = wr_iflag ? (flags_q & writedata[2:0]) : flags_q;
    assign flags_d = keep | evt;

    // bus handshake: one wait cycle, read data loaded alongside
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~((read | write) & wait_q);
            if (read & wait_q) begin
                readdata_q <= {24'h00_0000, rd_mux};
            end
        end
    end

    // software-written controls and the global enable
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tctrl_q <= TCTRL_RST;
            wctrl_q <= WCTRL_RST;
            imask_q <= IRQ_RST;
            clk_opt_q <= 1'b0;
            spare_q <= 2'h0;
        end else begin
            if (wr_tctrl) begin
                tctrl_q[5:0] <= writedata[5:0];
            end
            if (do_gie_clr) begin
                tctrl_q[TC_GIE] <= 1'b0;
            end else if (do_gie_set) begin
                tctrl_q[TC_GIE] <= 1'b1;
            end else if (wr_tctrl) begin
                tctrl_q[TC_GIE] <= writedata[TC_GIE];
            end
            if (wr_wctrl) begin
                wctrl_q <= {writedata[WC_WDOG_EN], writedata[WC_EXT_SEL]};
            end
            if (wr_imask) begin
                imask_q <= writedata[2:0];
            end
            if (wr_cfg) begin
                clk_opt_q <= writedata[0];
            end
            if (wr_status) begin
                spare_q <= {writedata[ST_SPARE_HI], writedata[ST_SPARE_LO]};
            end
        end
    end

    // tick counter, cycle divider and oscillator
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_q <= TICK_RST;
            cyc_q <= 2'd0;
            osc_q <= '0;
        end else begin
            cyc_q <= cyc_q + 2'd1;
            osc_q <= osc_tick ? '0 : osc_q + OSC_W'(1);
            if (wr_tick) begin
                tick_q <= writedata[7:0];
            end else if (tick_inc) begin
                tick_q <= tick_q + 8'h01;
            end
        end
    end

    // watchdog counter and its reset pulse
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wdt_q <= 8'h00;
            wdt_rst_q <= 1'b0;
        end else begin
            wdt_rst_q <= wdt_to;
            if (wdt_clr | wdt_to) begin
                wdt_q <= 8'h00;
            end else if (wdt_inc) begin
                wdt_q <= wdt_q + 8'h01;
            end
        end
    end

    // reset-cause flags and power state
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pd_q <= 1'b1;
            to_q <= 1'b1;
            rst_type_q <= 1'b0;
            state_q <= ST_RUN;
        end else begin
            if (do_kick) begin
                pd_q <= 1'b1;
            end else if (do_sleep) begin
                pd_q <= 1'b0;
            end
            if (wdt_to) begin
                to_q <= 1'b0;
            end else if (do_kick | do_sleep) begin
                to_q <= 1'b1;
            end
            if (wdt_to) begin
                rst_type_q <= 1'b0;
                state_q <= ST_RUN;
            end else if (wake) begin
                rst_type_q <= 1'b1;
                state_q <= ST_RUN;
            end else if (do_sleep) begin
                state_q <= ST_SLEEP;
            end
        end
    end

    // sticky flags, pin history and the interrupt request
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= IRQ_RST;
            cnt_prev_q <= 1'b0;
            ext_prev_q <= 1'b1;
            port_prev_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            cnt_prev_q <= count_pin;
            ext_prev_q <= ext_irq_pin;
            port_prev_q <= port_in;
            irq_q <= tctrl_q[TC_GIE] & (|(flags_q & imask_q));
        end
    end

    assign readdata = readdata_q;
    assign waitrequest = wait_q;
    assign watchdog_reset = wdt_rst_q;
    assign irq_request = irq_q;
    assign sleeping = state_q;
    assign count_pin_timer = tctrl_q[TC_SRC];
    assign ext_pin_irq = wctrl_q[0];

    property p_kick_pd;
        @(posedge mclk) disable iff (sys_rst) do_kick |=> pd_q && to_q;
    endproperty
    a_kick_pd: assert property (p_kick_pd) else $error("clear did not set flags");

    property p_sleep_pd;
        @(posedge mclk) disable iff (sys_rst) do_sleep && !do_kick && !wdt_to && !wake |=> !pd_q && sleeping;
    endproperty
    a_sleep_pd: assert property (p_sleep_pd) else $error("sleep flags wrong");

    property p_to_clear;
        @(posedge mclk) disable iff (sys_rst) wdt_to |=> !to_q && watchdog_reset;
    endproperty
    a_to_clear: assert property (p_to_clear) else $error("timeout not recorded");

    property p_wake_rst;
        @(posedge mclk) disable iff (sys_rst) wake && !wdt_to |=> rst_type_q && !sleeping;
    endproperty
    a_wake_rst: assert property (p_wake_rst) else $error("wake cause wrong");

    property p_wrap;
        @(posedge mclk) disable iff (sys_rst) tick_wrap |=> tick_q == 8'h00 && flags_q[IRQ_OVF];
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow not flagged");

    property p_no_set;
        @(posedge mclk) disable iff (sys_rst) evt == 3'h0 |=> (flags_q & ~$past(flags_q)) == 3'h0;
    endproperty
    a_no_set: assert property (p_no_set) else $error("flag set without event");

    property p_ext;
        @(posedge mclk) disable iff (sys_rst) $fell(ext_irq_pin) && ext_pin_irq |-> ##1 flags_q[IRQ_EXT];
    endproperty
    a_ext: assert property (p_ext) else $error("external edge lost");

    property p_gie_off;
        @(posedge mclk) disable iff (sys_rst) do_gie_clr |=> !tctrl_q[TC_GIE] ##1 !irq_request;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("global enable stuck");

    property p_irq_mask;
        @(posedge mclk) disable iff (sys_rst) ((flags_q & imask_q) == 3'h0) |=> !irq_request;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked source raised request");

    c_wrap: cover property (@(posedge mclk) disable iff (sys_rst) tick_wrap);
    c_wake: cover property (@(posedge mclk) disable iff (sys_rst) wake);
    c_timeout: cover property (@(posedge mclk) disable iff (sys_rst) wdt_to);
endmodule : timer_watchdog_irq_flags
`default_nettype wire

/* File: src/tmr_pkg.sv */
// constants shared by the timer, watchdog and interrupt-flag block
package tmr_pkg;
    // clock and watchdog timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int WDT_PERIOD_NS = 18_000_000;
    localparam int WDT_STEPS = 256;
    localparam int WDT_TICK_CYCLES = WDT_PERIOD_NS / (CLK_PERIOD_NS * WDT_STEPS);
    localparam int OSC_W = 16;
    // register byte addresses
    localparam logic [4:0] ADDR_TICK = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_IFLAG = 5'h08;
    localparam logic [4:0] ADDR_TCTRL = 5'h0c;
    localparam logic [4:0] ADDR_WCTRL = 5'h10;
    localparam logic [4:0] ADDR_IMASK = 5'h14;
    localparam logic [4:0] ADDR_CMD = 5'h18;
    localparam logic [4:0] ADDR_CFG = 5'h1c;
    // status_flags fields
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_SPARE_LO = 5;
    localparam int ST_SPARE_HI = 6;
    localparam int ST_RST = 7;
    // interrupt flag and mask fields
    localparam int IRQ_OVF = 0;
    localparam int IRQ_PIN = 1;
    localparam int IRQ_EXT = 2;
    // timer_control fields
    localparam int TC_ASSIGN = 3;
    localparam int TC_EDGE = 4;
    localparam int TC_SRC = 5;
    localparam int TC_GIE = 6;
    // watchdog_control fields
    localparam int WC_EXT_SEL = 6;
    localparam int WC_WDOG_EN = 7;
    // command bits, each a one-shot on write
    localparam int CMD_WDT_CLR = 0;
    localparam int CMD_SLEEP = 1;
    localparam int CMD_IRQ_ON = 2;
    localparam int CMD_IRQ_OFF = 3;
    localparam int CMD_IRQ_RET = 4;
    localparam int CMD_IRQ_TAKEN = 5;
    // reset values
    localparam logic [6:0] TCTRL_RST = 7'h3f;
    localparam logic [1:0] WCTRL_RST = 2'h2;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam logic [7:0] TICK_RST = 8'h00;
    // power state, one bit apart
    typedef enum logic {ST_RUN = 1'b0, ST_SLEEP = 1'b1} pwr_state_e;
endpackage : tmr_pkg
